// ### hdl/sew_defines.svh
`ifndef SEW_DEFINES_SVH
`define SEW_DEFINES_SVH

// ****************************************************************
// Device address and array layout
// ****************************************************************
`define SEW_DEV_TYPE 4'ha
`define SEW_RW_BIT 0
`define SEW_ERASED 8'hff
`define SEW_CELLS 256
`define SEW_PAGE_SIZE 8

// ****************************************************************
// Byte framing
// ****************************************************************
`define SEW_BIT_LAST 4'h8
`define SEW_ACK_SLOT 4'h9

// ****************************************************************
// Synchronised pin positions and their reset value
// ****************************************************************
`define SEW_PIN_SCL 5
`define SEW_PIN_SDA 4
`define SEW_PIN_WP 3
`define SEW_PIN_RST 6'h30

// ****************************************************************
// Timing
// ****************************************************************
`define SEW_TWR_MS 5
`define SEW_LINK_CLK_NS 32
`define SEW_TWR_CYCLES ((`SEW_TWR_MS * 1000000) / `SEW_LINK_CLK_NS)
`define SEW_TMR_W 18
`define SEW_CLK_NS 8
`define SEW_SCL_KHZ 400
`define SEW_QTR_DIV (4 * `SEW_CLK_NS * `SEW_SCL_KHZ)
`define SEW_QTR_CYCLES ((1000000 + `SEW_QTR_DIV - 1) / `SEW_QTR_DIV)

`endif

// ### hdl/sew_pkg.sv
`default_nettype none

package sew_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_WADDR = 3'h2,
    ST_WDATA = 3'h3,
    ST_READ = 3'h4
  } sew_dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_START = 2'h1,
    H_BIT = 2'h2,
    H_STOP = 2'h3
  } sew_host_state_t;

  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_STOP = 2'h1,
    CMD_WRITE = 2'h2,
    CMD_READ = 2'h3
  } sew_cmd_t;

endpackage

`default_nettype wire

// ### hdl/sew_bus_if.sv
`timescale 1ns/100ps
`default_nettype none

interface sew_bus_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // Open-drain data line with pull-up: any enabled low drive wins.
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport host (
    output scl,
    output host_sda_o,
    output host_sda_oe,
    input sda
  );

  modport device (
    input scl,
    output dev_sda_o,
    output dev_sda_oe,
    input sda
  );
endinterface

`default_nettype wire

// ### hdl/sew_device.sv
`timescale 1ns/100ps
`default_nettype none
`include "sew_defines.svh"


module sew_device
  import sew_pkg::*;
#(
  parameter int WR_CYCLES = `SEW_TWR_CYCLES
) (
  // Link clock and reset
  input wire logic link_clk,
  input wire logic nrst,
  // Two-wire bus
  sew_bus_if.device bus,
  // Strap and protect pins
  input wire logic chip_select_bit0_pin,
  input wire logic chip_select_bit1_pin,
  input wire logic chip_select_bit2_pin,
  input wire logic write_protect_pin,
  // Status
  output logic standby,
  output logic write_busy
);

  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic scl_prev;
  logic sda_prev;
  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic [2:0] cs_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  sew_dev_state_t state;
  logic rx_state;
  logic [3:0] bitcnt;
  logic [7:0] shift;
  logic [7:0] tx;
  logic sda_oe;
  logic ack_seen;
  logic addr_match;
  logic accept;
  logic byte_done;
  logic [7:0] addr;
  logic [7:0] rd_byte;
  logic [7:0] dirty;
  logic [7:0] pbuf [`SEW_PAGE_SIZE];
  logic [7:0] mem [`SEW_CELLS];
  logic commit;
  logic busy;
  logic [`SEW_TMR_W-1:0] timer;

  // ****************************************************************
  // Pin synchronisers and bus events
  // ****************************************************************
  always_ff @(posedge link_clk) begin
    if (!nrst) begin
      pin_meta <= `SEW_PIN_RST;
      pin_sync <= `SEW_PIN_RST;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      pin_meta <= {bus.scl, bus.sda, write_protect_pin, chip_select_bit2_pin,
                   chip_select_bit1_pin, chip_select_bit0_pin};
      pin_sync <= pin_meta;
      scl_prev <= scl_s;
      sda_prev <= sda_s;
    end
  end

  assign scl_s = pin_sync[`SEW_PIN_SCL];
  assign sda_s = pin_sync[`SEW_PIN_SDA];
  assign wp_s = pin_sync[`SEW_PIN_WP];
  assign cs_s = pin_sync[2:0];
  assign scl_rise = scl_s & ~scl_prev;
  assign scl_fall = ~scl_s & scl_prev;
  assign start_det = scl_s & scl_prev & sda_prev & ~sda_s;
  assign stop_det = scl_s & scl_prev & ~sda_prev & sda_s;

  // ****************************************************************
  // Byte decode
  // ****************************************************************
  assign rx_state = (state == ST_ADDR) || (state == ST_WADDR) || (state == ST_WDATA);
  assign addr_match = (shift[7:4] == `SEW_DEV_TYPE)
                      && (shift[3:1] == cs_s)
                      && !busy;
  assign accept = (state == ST_ADDR) ? addr_match : 1'b1;
  assign byte_done = scl_fall && rx_state && (bitcnt == `SEW_BIT_LAST);
  assign rd_byte = mem[addr];

  // ****************************************************************
  // Protocol engine
  // ****************************************************************
  always_ff @(posedge link_clk) begin
    if (!nrst) begin
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      sda_oe <= 1'b0;
      ack_seen <= 1'b0;
    end else if (start_det) begin
      state <= ST_ADDR;
      bitcnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (scl_rise && state == ST_READ) begin
      if (bitcnt == `SEW_BIT_LAST) begin
        ack_seen <= ~sda_s;
        bitcnt <= `SEW_ACK_SLOT;
      end else if (bitcnt < `SEW_BIT_LAST) begin
        bitcnt <= bitcnt + 4'h1;
      end
    end else if (scl_rise && rx_state && bitcnt < `SEW_BIT_LAST) begin
      shift <= {shift[6:0], sda_s};
      bitcnt <= bitcnt + 4'h1;
    end else if (scl_fall) begin
      case (state)
        ST_ADDR, ST_WADDR, ST_WDATA: begin
          if (bitcnt == `SEW_BIT_LAST) begin
            bitcnt <= `SEW_ACK_SLOT;
            sda_oe <= accept;
            if (!accept) begin
              state <= ST_IDLE;
            end
          end else if (bitcnt == `SEW_ACK_SLOT) begin
            bitcnt <= 4'h0;
            if (state == ST_ADDR && shift[`SEW_RW_BIT]) begin
              state <= ST_READ;
              tx <= rd_byte;
              sda_oe <= ~rd_byte[7];
            end else begin
              sda_oe <= 1'b0;
              state <= (state == ST_ADDR) ? ST_WADDR : ST_WDATA;
            end
          end
        end
        ST_READ: begin
          if (bitcnt == `SEW_ACK_SLOT) begin
            bitcnt <= 4'h0;
            if (ack_seen) begin
              tx <= rd_byte;
              sda_oe <= ~rd_byte[7];
            end else begin
              state <= ST_IDLE;
              sda_oe <= 1'b0;
            end
          end else if (bitcnt == `SEW_BIT_LAST) begin
            sda_oe <= 1'b0;
          end else if (bitcnt != 4'h0) begin
            tx <= {tx[6:0], 1'b0};
            sda_oe <= ~tx[6];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Address counter
  // ****************************************************************
  always_ff @(posedge link_clk) begin
    if (!nrst) begin
      addr <= 8'h00;
    end else if (byte_done && state == ST_WADDR) begin
      addr <= shift;
    end else if (byte_done && state == ST_WDATA) begin
      addr <= {addr[7:3], addr[2:0] + 3'h1};
    end else if (scl_rise && state == ST_READ && bitcnt == `SEW_BIT_LAST) begin
      addr <= addr + 8'h01;
    end
  end

  // ****************************************************************
  // Page buffer
  // ****************************************************************
  always_ff @(posedge link_clk) begin
    if (!nrst) begin
      dirty <= 8'h00;
    end else if (start_det || stop_det) begin
      dirty <= 8'h00;
    end else if (byte_done && state == ST_WDATA) begin
      dirty[addr[2:0]] <= 1'b1;
    end
  end

  always_ff @(posedge link_clk) begin
    if (byte_done && state == ST_WDATA) begin
      pbuf[addr[2:0]] <= shift;
    end
  end

  // ****************************************************************
  // Self-timed write cycle
  // ****************************************************************
  assign commit = stop_det && (|dirty) && !wp_s && !busy;

  always_ff @(posedge link_clk) begin
    if (!nrst) begin
      busy <= 1'b0;
      timer <= '0;
    end else if (commit) begin
      busy <= 1'b1;
      timer <= `SEW_TMR_W'(WR_CYCLES - 1);
    end else if (busy) begin
      if (timer == '0) begin
        busy <= 1'b0;
      end else begin
        timer <= timer - `SEW_TMR_W'(1);
      end
    end
  end

  // ****************************************************************
  // Memory array
  // ****************************************************************
  for (genvar j = 0; j < `SEW_CELLS; j++) begin : g_cell
    localparam logic [7:0] CELL = 8'(j);
    always_ff @(posedge link_clk) begin
      if (!nrst) begin
        mem[j] <= `SEW_ERASED;
      end else if (commit && addr[7:3] == CELL[7:3] && dirty[CELL[2:0]]) begin
        mem[j] <= pbuf[CELL[2:0]];
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = sda_oe;
  assign standby = (state == ST_IDLE) && !busy;
  assign write_busy = busy;

endmodule

`default_nettype wire

// ### hdl/sew_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "sew_defines.svh"

module sew_host
  import sew_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Two-wire bus
  sew_bus_if.host bus,
  // Command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire sew_cmd_t cmd,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_ack,
  // Response
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_ack
);

  sew_host_state_t hstate;
  logic [7:0] qcnt;
  logic tick;
  logic [1:0] q;
  logic [3:0] bitn;
  logic [8:0] txd;
  logic scl;
  logic sda_oe;
  logic sda_meta;
  logic sda_s;

  // ****************************************************************
  // Data line synchroniser
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sda_meta <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      sda_meta <= bus.sda;
      sda_s <= sda_meta;
    end
  end

  // ****************************************************************
  // Quarter-period divider for the bus clock
  // ****************************************************************
  assign tick = (qcnt == 8'(`SEW_QTR_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!nrst || hstate == H_IDLE || tick) begin
      qcnt <= 8'h00;
    end else begin
      qcnt <= qcnt + 8'h01;
    end
  end

  // ****************************************************************
  // Bus sequencer
  // ****************************************************************
  assign cmd_ready = (hstate == H_IDLE);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      hstate <= H_IDLE;
      q <= 2'h0;
      bitn <= 4'h0;
      txd <= 9'h1ff;
      scl <= 1'b1;
      sda_oe <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_ack <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      if (hstate == H_IDLE) begin
        q <= 2'h0;
        bitn <= 4'h0;
        if (cmd_valid) begin
          case (cmd)
            CMD_START: hstate <= H_START;
            CMD_STOP: hstate <= H_STOP;
            CMD_WRITE: begin
              hstate <= H_BIT;
              txd <= {cmd_data, 1'b1};
            end
            default: begin
              hstate <= H_BIT;
              txd <= {8'hff, ~cmd_ack};
            end
          endcase
        end
      end else if (tick) begin
        q <= q + 2'h1;
        case (hstate)
          H_START: begin
            case (q)
              2'h0: sda_oe <= 1'b0;
              2'h1: scl <= 1'b1;
              2'h2: sda_oe <= 1'b1;
              default: begin
                scl <= 1'b0;
                hstate <= H_IDLE;
                rsp_valid <= 1'b1;
              end
            endcase
          end
          H_STOP: begin
            case (q)
              2'h0: sda_oe <= 1'b1;
              2'h1: scl <= 1'b1;
              2'h2: sda_oe <= 1'b0;
              default: begin
                hstate <= H_IDLE;
                rsp_valid <= 1'b1;
              end
            endcase
          end
          default: begin
            case (q)
              2'h0: sda_oe <= ~txd[8];
              2'h1: scl <= 1'b1;
              2'h2: begin
                if (bitn == `SEW_BIT_LAST) begin
                  rsp_ack <= ~sda_s;
                end else begin
                  rsp_data <= {rsp_data[6:0], sda_s};
                end
              end
              default: begin
                scl <= 1'b0;
                txd <= {txd[7:0], 1'b1};
                if (bitn == `SEW_BIT_LAST) begin
                  hstate <= H_IDLE;
                  rsp_valid <= 1'b1;
                end else begin
                  bitn <= bitn + 4'h1;
                end
              end
            endcase
          end
        endcase
      end
    end
  end

  assign bus.scl = scl;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = sda_oe;

endmodule

`default_nettype wire

// ### tb/sew_bus_properties.sv
`timescale 1ns/100ps
`default_nettype none

module sew_bus_properties #(
  parameter int WR_CYCLES = 1000
) (
  // Clock and reset
  input wire logic link_clk,
  input wire logic nrst,
  // Bus wires
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda,
  // Device status
  input wire logic standby,
  input wire logic write_busy
);
  logic [31:0] busy_cnt;

  default clocking cb @(posedge link_clk);
  endclocking
  default disable iff (!nrst);

  // ********************
  // Helpers
  // ********************
  // Counts the cycles of the internal write cycle.
  always_ff @(posedge link_clk) begin
    if (!nrst) begin
      busy_cnt <= 32'h0;
    end else if (write_busy) begin
      busy_cnt <= busy_cnt + 32'h1;
    end else begin
      busy_cnt <= 32'h0;
    end
  end

  sequence stop_seen;
    scl && $past(scl) && !$past(sda) && sda;
  endsequence

  sequence drive_start;
    $rose(dev_sda_oe);
  endsequence

  // ********************
  // Properties
  // ********************
  a_reset_idle: assert property ($rose(nrst) |-> scl && !host_sda_oe && !dev_sda_oe
    && standby && !write_busy) else $error("bus not idle after reset");
  a_open_drain: assert property (!dev_sda_o && !host_sda_o)
    else $error("data line driven high");
  a_dev_change_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device data changed while clock high");
  a_drive_hold: assert property (drive_start |-> dev_sda_oe [*8])
    else $error("device drive too short");
  a_stop_idle: assert property (stop_seen |-> ##[1:8] (standby || write_busy))
    else $error("device not idle after stop");
  a_busy_silent: assert property (write_busy |-> !dev_sda_oe && !standby)
    else $error("device active during write cycle");
  a_busy_end_idle: assert property ($fell(write_busy) |-> standby)
    else $error("no standby after write cycle");
  a_busy_length: assert property ($fell(write_busy) |-> busy_cnt >= 32'(WR_CYCLES - 1)
    && busy_cnt <= 32'(WR_CYCLES + 1)) else $error("write cycle length wrong");
endmodule

`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb
  import sew_pkg::*;
;
  localparam int WR = 1000;
  localparam logic [7:0] DW = 8'haa;
  localparam logic [7:0] DR = 8'hab;
  localparam logic [7:0] PAT [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
  localparam logic [7:0] BAD [2] = '{8'ha8, 8'hba};
  logic clk, link_clk, nrst, cmd_valid, cmd_ready, cmd_ack, rsp_valid, rsp_ack;
  logic wp, standby, write_busy;
  logic [7:0] cmd_data, rsp_data;
  logic [2:0] cs;
  sew_cmd_t cmd;
  int failures, checked;

  // ********************
  // Design and checker
  // ********************
  sew_bus_if bus();
  sew_host u_sew_host (.clk(clk), .nrst(nrst), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .cmd_data(cmd_data), .cmd_ack(cmd_ack),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
  sew_device #(.WR_CYCLES(WR)) u_sew_device (.link_clk(link_clk), .nrst(nrst), .bus(bus),
    .chip_select_bit0_pin(cs[0]), .chip_select_bit1_pin(cs[1]), .chip_select_bit2_pin(cs[2]),
    .write_protect_pin(wp), .standby(standby), .write_busy(write_busy));
  sew_bus_properties #(.WR_CYCLES(WR)) u_sew_bus_properties (.link_clk(link_clk), .nrst(nrst),
    .scl(bus.scl), .host_sda_o(bus.host_sda_o), .host_sda_oe(bus.host_sda_oe),
    .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe), .sda(bus.sda),
    .standby(standby), .write_busy(write_busy));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    link_clk = 1'b0;
    #3;
    forever #16 link_clk = ~link_clk;
  end

  // ********************
  // Tasks
  // ********************
  task automatic chk_bit(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic issue(input sew_cmd_t c, input logic [7:0] d, input logic a);
    int n;
    @(negedge clk);
    cmd = c;
    cmd_data = d;
    cmd_ack = a;
    cmd_valid = 1'b1;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk_bit("cmd_ready", 1'b1, cmd_ready);
    @(negedge clk);
    cmd_valid = 1'b0;
    chk_bit("cmd_ready_taken", 1'b0, cmd_ready);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    chk_bit("rsp_valid", 1'b1, rsp_valid);
  endtask

  task automatic st();
    issue(CMD_START, 8'h00, 1'b0);
  endtask

  task automatic sp();
    issue(CMD_STOP, 8'h00, 1'b0);
  endtask

  task automatic wr(input logic [7:0] d, input logic exp_ack);
    issue(CMD_WRITE, d, 1'b0);
    chk_bit("ack", exp_ack, rsp_ack);
  endtask

  task automatic rd(input logic ack, input logic [7:0] exp);
    issue(CMD_READ, 8'h00, ack);
    chk_byte("rdata", exp, rsp_data);
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic sc_page_write();
    st();
    wr(DW, 1'b1);
    wr(8'h06, 1'b1);
    for (int i = 0; i < 4; i++) wr(PAT[i], 1'b1);
    sp();
    repeat (40) @(negedge clk);
    chk_bit("write_busy", 1'b1, write_busy);
  endtask

  task automatic sc_poll_read();
    int n;
    st();
    wr(DW, 1'b0);
    sp();
    n = 0;
    while (write_busy !== 1'b0 && n < 8000) begin
      @(negedge clk);
      n++;
    end
    chk_bit("write_busy", 1'b0, write_busy);
    chk_bit("standby", 1'b1, standby);
    st();
    wr(DW, 1'b1);
    wr(8'h06, 1'b1);
    st();
    wr(DR, 1'b1);
    rd(1'b1, 8'h11);
    rd(1'b1, 8'h22);
    rd(1'b0, 8'hff);
    sp();
    chk_bit("standby", 1'b1, standby);
  endtask

  task automatic sc_wrap_read();
    st();
    wr(DW, 1'b1);
    wr(8'hff, 1'b1);
    st();
    wr(DR, 1'b1);
    rd(1'b1, 8'hff);
    rd(1'b0, 8'h33);
    sp();
    st();
    wr(DR, 1'b1);
    rd(1'b0, 8'h44);
    sp();
  endtask

  task automatic sc_mismatch();
    for (int i = 0; i < 2; i++) begin
      st();
      wr(BAD[i], 1'b0);
      sp();
      chk_bit("standby", 1'b1, standby);
    end
  endtask

  task automatic sc_write_protect();
    wp = 1'b1;
    st();
    wr(DW, 1'b1);
    wr(8'h06, 1'b1);
    wr(8'h5a, 1'b1);
    sp();
    repeat (40) @(negedge clk);
    chk_bit("write_busy", 1'b0, write_busy);
    wp = 1'b0;
  endtask

  task automatic sc_soft_reset();
    st();
    wr(DW, 1'b1);
    wr(8'h06, 1'b1);
    st();
    wr(8'hff, 1'b0);
    st();
    sp();
    chk_bit("standby", 1'b1, standby);
    st();
    wr(DW, 1'b1);
    sp();
  endtask

  task automatic report_and_stop();
    if (failures == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ********************
  // Run
  // ********************
  initial begin
    nrst = 1'b0;
    cmd_valid = 1'b0;
    cmd = CMD_START;
    cmd_data = 8'h00;
    cmd_ack = 1'b0;
    wp = 1'b0;
    cs = 3'h5;
    failures = 0;
    checked = 0;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    repeat (16) @(negedge clk);
    sc_page_write();
    sc_poll_read();
    sc_wrap_read();
    sc_mismatch();
    sc_write_protect();
    sc_soft_reset();
    report_and_stop();
  end

  initial begin
    repeat (98000) @(posedge clk);
    failures++;
    report_and_stop();
  end
endmodule

`default_nettype wire
